// ===== dv/itb_host.sv
// processor model issuing timer port cycles
`timescale 1ns/100ps
module itb_host (
	// system
	input wire logic  sys_clk,
	// host bus
	output logic       dev_sel_n,
	output logic       rd_n,
	output logic       wr_n,
	output logic [1:0] port,
	output logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic   data_oe
);
	initial begin
		{dev_sel_n, rd_n, wr_n, port, data_in} = {3'h7, 2'h0, 8'h00};
	end
	task automatic acc(input logic w, input logic s_n, input logic [1:0] p, input logic [7:0] d,
		output logic [7:0] q, output logic oe);
		@(posedge sys_clk) #1;
		dev_sel_n = s_n;
		port = p;
		data_in = d;
		@(posedge sys_clk) #1;
		{rd_n, wr_n} = {w, !w};
		repeat (6) @(posedge sys_clk);
		#1;
		q = data_out;
		oe = data_oe;
		{rd_n, wr_n} = 2'h3;
		dev_sel_n = 1'h1;
		data_in = ~d;
		repeat (6) @(posedge sys_clk);
	endtask : acc
endmodule : itb_host

// ===== dv/itb_timer_sva.sv
// assertions on the interval timer bus port pins
`timescale 1ns/100ps
module itb_timer_sva
	import itb_pkg::*;
(
	// system
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// host bus
	input wire logic       dev_sel_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic       port_select_bit0,
	input wire logic       port_select_bit1,
	input wire logic       data_oe,
	// counter pins
	input wire logic [2:0] cnt_clk,
	input wire logic [2:0] cnt_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire p3 = port_select_bit1 & port_select_bit0;
	a_idle_undriven: assert property (rd_n [*5] |=> !data_oe)
		else $error("bus driven without read");
	a_desel_undriven: assert property (dev_sel_n [*5] |=> !data_oe)
		else $error("bus driven while deselected");
	a_mode_read_nop: assert property ((!rd_n && p3) [*6] |-> !data_oe)
		else $error("mode port read drove bus");
	a_read_answer: assert property ($fell(rd_n) && wr_n && !dev_sel_n && $past(!dev_sel_n) && !p3 |-> ##[3:5] data_oe)
		else $error("read not answered");
	a_read_release: assert property ($rose(rd_n) |-> ##[1:5] !data_oe)
		else $error("bus held after read");
	a_write_undriven: assert property ((!wr_n) [*6] |-> !data_oe)
		else $error("bus driven during write");
	a_oe_cause: assert property ($rose(data_oe) |-> !rd_n && !dev_sel_n && !p3)
		else $error("bus drive without selected read");
	a_out_steady: assert property ((wr_n && $stable(cnt_clk)) [*8] |-> $stable(cnt_out))
		else $error("output moved without cause");
endmodule : itb_timer_sva
bind itb_timer itb_timer_sva i_itb_timer_sva (.sys_clk, .rst_n, .dev_sel_n, .rd_n, .wr_n,
	.port_select_bit0, .port_select_bit1, .data_oe, .cnt_clk, .cnt_out);

// ===== dv/itb_timer_tb.sv
// self-checking bench for the interval timer bus port
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch %0t got %h want %h", $time, g, e); end end
module itb_timer_tb;
	import itb_pkg::*;
	logic sys_clk = 0, rst_n = 0, dev_sel_n, rd_n, wr_n, oe;
	logic [1:0] port;
	logic [7:0] data_in, data_out, q;
	logic [2:0] cclk = 0, cnt_out;
	wire data_oe;
	int miscompares = 0, n_tests = 0, cyc = 0;
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (++cyc == 3000) begin
		miscompares++;
		tally_and_finish;
	end
	itb_host i_itb_host (.sys_clk, .dev_sel_n, .rd_n, .wr_n, .port, .data_in, .data_out, .data_oe);
	itb_timer i_itb_timer (.sys_clk, .rst_n, .dev_sel_n, .rd_n, .wr_n, .port_select_bit0(port[0]),
		.port_select_bit1(port[1]), .data_in, .data_out, .data_oe, .cnt_clk(cclk), .cnt_gate(3'h7), .cnt_out);
	task automatic pulse(input int c);
		repeat (8) @(posedge sys_clk) #1;
		cclk[c] = 1'h1;
		repeat (8) @(posedge sys_clk) #1;
		cclk[c] = 1'h0;
		repeat (8) @(posedge sys_clk);
	endtask : pulse
	task automatic t_load_read;
		i_itb_host.acc(1, 0, ITB_PORT_MODE, 8'h70, q, oe);
		i_itb_host.acc(1, 0, ITB_PORT_CNT1, 8'h34, q, oe);
		i_itb_host.acc(1, 0, ITB_PORT_CNT1, 8'h12, q, oe);
		i_itb_host.acc(1, 1, ITB_PORT_CNT1, 8'h99, q, oe);
		pulse(1);
		i_itb_host.acc(0, 1, ITB_PORT_CNT1, 8'h00, q, oe);
		`CHK(oe, 1'h0)
		i_itb_host.acc(0, 0, ITB_PORT_MODE, 8'h00, q, oe);
		`CHK(oe, 1'h0)
		i_itb_host.acc(0, 0, ITB_PORT_CNT1, 8'h00, q, oe);
		`CHK({oe, q}, 9'h134)
		i_itb_host.acc(0, 0, ITB_PORT_CNT1, 8'h00, q, oe);
		`CHK({oe, q}, 9'h112)
		$display("t_load_read done");
	endtask : t_load_read
	task automatic t_count_done;
		i_itb_host.acc(1, 0, ITB_PORT_MODE, 8'h30, q, oe);
		i_itb_host.acc(1, 0, ITB_PORT_CNT0, 8'h02, q, oe);
		i_itb_host.acc(1, 0, ITB_PORT_CNT0, 8'h00, q, oe);
		`CHK(cnt_out[0], 1'h0)
		pulse(0);
		pulse(0);
		`CHK(cnt_out[0], 1'h0)
		pulse(0);
		`CHK(cnt_out[0], 1'h1)
		i_itb_host.acc(1, 0, ITB_PORT_MODE, 8'hf0, q, oe);
		`CHK(cnt_out[0], 1'h1)
		$display("t_count_done done");
	endtask : t_count_done
	task automatic t_bcd_latch;
		i_itb_host.acc(1, 0, ITB_PORT_MODE, 8'hb1, q, oe);
		i_itb_host.acc(1, 0, ITB_PORT_CNT2, 8'h00, q, oe);
		i_itb_host.acc(1, 0, ITB_PORT_CNT2, 8'h10, q, oe);
		pulse(2);
		pulse(2);
		i_itb_host.acc(1, 0, ITB_PORT_MODE, 8'h80, q, oe);
		i_itb_host.acc(0, 0, ITB_PORT_CNT2, 8'h00, q, oe);
		`CHK({oe, q}, 9'h199)
		i_itb_host.acc(0, 0, ITB_PORT_CNT2, 8'h00, q, oe);
		`CHK({oe, q}, 9'h109)
		$display("t_bcd_latch done");
	endtask : t_bcd_latch
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (8) @(posedge sys_clk) #1;
		rst_n = 1'h1;
		repeat (6) @(posedge sys_clk);
		t_load_read;
		t_count_done;
		t_bcd_latch;
		tally_and_finish;
	end
endmodule : itb_timer_tb

// ===== hdl/itb_pkg.sv
// constants and types for the interval timer bus port
package itb_pkg;
	localparam logic [1:0] ITB_PORT_CNT0   = 2'h0;
	localparam logic [1:0] ITB_PORT_CNT1   = 2'h1;
	localparam logic [1:0] ITB_PORT_CNT2   = 2'h2;
	localparam logic [1:0] ITB_PORT_MODE   = 2'h3;
	localparam int         ITB_SEL_MSB     = 7;
	localparam int         ITB_SEL_LSB     = 6;
	localparam int         ITB_ORDER_MSB   = 5;
	localparam int         ITB_ORDER_LSB   = 4;
	localparam int         ITB_MODE_MSB    = 3;
	localparam int         ITB_MODE_LSB    = 1;
	localparam int         ITB_BCD_BIT     = 0;
	localparam logic [1:0] ITB_ORDER_LATCH = 2'h0;
	localparam logic [1:0] ITB_ORDER_LSB_O = 2'h1;
	localparam logic [1:0] ITB_ORDER_MSB_O = 2'h2;
	localparam logic [1:0] ITB_ORDER_BOTH  = 2'h3;
	localparam logic [7:0]  ITB_CTRL_RST   = 8'h00;
	localparam logic [15:0] ITB_CNT_RST    = 16'h0000;
	localparam logic [2:0]  ITB_SYNC_RST   = 3'h0;
	localparam logic [2:0]  ITB_MODE_STROBE = 3'h4;
	localparam logic [2:0]  ITB_MODE_SWAVE  = 3'h3;

	typedef struct packed {
		logic [5:0]  ctrl;
		logic [15:0] cnt;
		logic [15:0] preset;
		logic [15:0] latch;
		logic        latched;
		logic        wr_hi;
		logic        rd_hi;
		logic        pend;
		logic        armed;
		logic        done;
		logic [2:0]  clk_s;
		logic [2:0]  gate_s;
		logic        clk_q;
		logic        gate_q;
	} itb_chan_t;
endpackage : itb_pkg

// ===== hdl/itb_timer.sv
// three channel interval timer with its bus port decode
//
// Summary of operation
// R1 - accesses ignored and data bus undriven unless device select is low
// R2 - device select has no effect on counting or outputs
// R3 - 8-bit data bus driven only during selected read
// R4 - selected read strobe puts addressed counter value on data bus
// R5 - selected write strobe captures data bus byte
// R6 - port select 0,1,2 address counters zero, one, two
// R7 - port select 3 write stores mode word; read is no-op, undriven
// R8 - three independent 16-bit loadable readable counters
// R9 - all modes chosen by bus writes, no strapping
// R10 - loaded counter counts out delay then signals completion; only mode 0 does so, other modes hold output high from the mode write on
// R11 - mode word: counter choice, byte order, mode, BCD; choice 3 illegal
// R12 - mode word is write only
// R13 - each counter counts binary or four-decade BCD per mode bit
// R14 - count takes effect after rising then falling counter clock edge
// R15 - host never asserts read and write together
`timescale 1ns/100ps
module itb_timer
	import itb_pkg::*;
(
	// system
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// host bus
	input  wire logic       dev_sel_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       port_select_bit0,
	input  wire logic       port_select_bit1,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	// counter pins
	input  wire logic [2:0] cnt_clk,
	input  wire logic [2:0] cnt_gate,
	output logic      [2:0] cnt_out
);
	typedef struct packed {
		itb_chan_t [2:0] ch;
		logic [2:0]      rd_s;
		logic [2:0]      wr_s;
		logic [2:0]      cs_s;
		logic [7:0]      dout;
		logic            oe;
		logic [2:0]      outs;
	} itb_state_t;

	itb_state_t s_r, s_nxt;

	// one step down, binary or bcd
	function automatic logic [15:0] itb_dec(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		r = v;
		if (!bcd) begin
			r = v - 16'h0001;
		end else begin
			for (int d = 0; d < 4; d++) begin
				if (r[d*4 +: 4] != 4'h0) begin
					r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
					break;
				end
				r[d*4 +: 4] = 4'h9;
			end
		end
		return r;
	endfunction : itb_dec

	logic       rd_ev;
	logic       wr_ev;
	logic [1:0] port;

	always_comb begin
		s_nxt = s_r;
		port  = {port_select_bit1, port_select_bit0};
		s_nxt.rd_s = {s_r.rd_s[1:0], ~rd_n};
		s_nxt.wr_s = {s_r.wr_s[1:0], ~wr_n};
		s_nxt.cs_s = {s_r.cs_s[1:0], ~dev_sel_n};
		// strobe leading edges where stage two is set and stage three is still clear
		rd_ev = s_r.rd_s[1] & ~s_r.rd_s[2] & s_r.cs_s[1] & s_r.cs_s[2]; // R1 R4
		wr_ev = s_r.wr_s[1] & ~s_r.wr_s[2] & s_r.cs_s[1] & s_r.cs_s[2] & ~s_r.rd_s[2]; // R1 R5 R15
		// drive bus only in a selected read of a counter port
		s_nxt.oe = s_r.rd_s[1] & s_r.rd_s[2] & s_r.cs_s[1] & s_r.cs_s[2]
			& (port != ITB_PORT_MODE); // R1 R3 R7 R12
		for (int i = 0; i < 3; i++) begin
			s_nxt.ch[i].clk_s  = {s_r.ch[i].clk_s[1:0], cnt_clk[i]};
			s_nxt.ch[i].gate_s = {s_r.ch[i].gate_s[1:0], cnt_gate[i]};
			if (s_r.ch[i].clk_s[1] == s_r.ch[i].clk_s[2]) begin
				s_nxt.ch[i].clk_q = s_r.ch[i].clk_s[2];
			end
			if (s_r.ch[i].gate_s[1] == s_r.ch[i].gate_s[2]) begin
				s_nxt.ch[i].gate_q = s_r.ch[i].gate_s[2];
			end
			// mode word write for this channel
			if (wr_ev && port == ITB_PORT_MODE && s_r.wr_s[1]
				&& data_in[ITB_SEL_MSB:ITB_SEL_LSB] == 2'(i)) begin // R7 R9 R11
				if (data_in[ITB_ORDER_MSB:ITB_ORDER_LSB] == ITB_ORDER_LATCH) begin
					s_nxt.ch[i].latch   = s_r.ch[i].cnt;
					s_nxt.ch[i].latched = 1'b1;
				end else begin
					s_nxt.ch[i].ctrl  = data_in[5:0];
					s_nxt.ch[i].wr_hi = 1'b0;
					s_nxt.ch[i].rd_hi = 1'b0;
					s_nxt.ch[i].armed = 1'b0;
					s_nxt.ch[i].done  = (data_in[ITB_MODE_MSB:ITB_MODE_LSB] != 3'h0);
				end
			end
			// count byte writes
			if (wr_ev && port == 2'(i)) begin // R5 R6 R8
				unique case (s_r.ch[i].ctrl[ITB_ORDER_MSB:ITB_ORDER_LSB])
					ITB_ORDER_LSB_O: begin
						s_nxt.ch[i].preset = {8'h00, data_in};
						s_nxt.ch[i].pend   = 1'b1;
					end
					ITB_ORDER_MSB_O: begin
						s_nxt.ch[i].preset = {data_in, 8'h00};
						s_nxt.ch[i].pend   = 1'b1;
					end
					ITB_ORDER_BOTH: begin
						if (!s_r.ch[i].wr_hi) begin
							s_nxt.ch[i].preset[7:0] = data_in;
							s_nxt.ch[i].wr_hi       = 1'b1;
							s_nxt.ch[i].armed       = 1'b0;
						end else begin
							s_nxt.ch[i].preset[15:8] = data_in;
							s_nxt.ch[i].wr_hi        = 1'b0;
							s_nxt.ch[i].pend         = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
			// counting on falling counter clock, independent of select
			if (s_r.ch[i].clk_q && !s_nxt.ch[i].clk_q) begin // R2 R8
				if (s_r.ch[i].pend) begin
					s_nxt.ch[i].cnt   = s_r.ch[i].preset; // R14
					s_nxt.ch[i].pend  = 1'b0;
					s_nxt.ch[i].armed = 1'b1;
					s_nxt.ch[i].done  = (s_r.ch[i].ctrl[ITB_MODE_MSB:ITB_MODE_LSB] != 3'h0);
				end else if (s_r.ch[i].armed && s_r.ch[i].gate_q) begin
					s_nxt.ch[i].cnt = itb_dec(s_r.ch[i].cnt, s_r.ch[i].ctrl[ITB_BCD_BIT]); // R13
					if (s_r.ch[i].cnt == 16'h0001) begin
						s_nxt.ch[i].done = 1'b1; // R10
					end
				end
			end
			s_nxt.outs[i] = s_r.ch[i].done;
			// counter read bytes
			if (rd_ev && port == 2'(i)) begin // R4 R6
				logic [15:0] v;
				v = s_r.ch[i].latched ? s_r.ch[i].latch : s_r.ch[i].cnt;
				unique case (s_r.ch[i].ctrl[ITB_ORDER_MSB:ITB_ORDER_LSB])
					ITB_ORDER_MSB_O: begin
						s_nxt.dout            = v[15:8];
						s_nxt.ch[i].latched   = 1'b0;
					end
					ITB_ORDER_BOTH: begin
						s_nxt.dout          = s_r.ch[i].rd_hi ? v[15:8] : v[7:0];
						s_nxt.ch[i].rd_hi   = ~s_r.ch[i].rd_hi;
						s_nxt.ch[i].latched = s_r.ch[i].latched & ~s_r.ch[i].rd_hi;
					end
					default: begin
						s_nxt.dout          = v[7:0];
						s_nxt.ch[i].latched = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign data_out = s_r.dout;
	assign data_oe  = s_r.oe;
	assign cnt_out  = s_r.outs;
endmodule : itb_timer
